// file: hw/sfdpd_rom.sv
`timescale 1ns/1ps
`include "sfdpd_map.svh"

module sfdpd_rom
    import sfdpd_pkg::*;
#(
    parameter int ADDR_W = `SFDPD_ADDR_BITS
) (
    // Lookup
    input wire logic [ADDR_W-1:0] addr,
    output sfdpd_byte_t data
);

    // Builds a latency locator word
    function automatic logic [31:0] locator(input logic [1:0] width, input logic [2:0] lsb);
        locator = {`SFDPD_SUPPORTED, width, `SFDPD_ADDRESSED,
                   `SFDPD_LAST_BYTE, lsb,
                   `SFDPD_CR3_ADDR,
                   `SFDPD_RD_CMD,
                   `SFDPD_WR_CMD};
    endfunction

    // Builds the long latency word, one flag then one pattern per latency
    function automatic logic [31:0] long_word(input logic [4:0] flags, input logic [4:0] pat);
        logic [31:0] w;
        w = 32'h0000_0000;
        for (int i = 0; i < 5; i++) begin
            w[31 - 6*i] = flags[4-i];
            w[30 - 6*i -: 5] = pat;
        end
        w[1:0] = `SFDPD_RSVD;
        long_word = w;
    endfunction

    logic [31:0] vol_word;
    logic [31:0] nvl_word;
    logic [31:0] long_w;
    logic [31:0] sel_word;
    logic hit;

    assign vol_word = locator(`SFDPD_VOL_WIDTH, `SFDPD_VOL_LSB);
    assign nvl_word = locator(`SFDPD_NVL_WIDTH, `SFDPD_NVL_LSB);
    assign long_w = long_word(`SFDPD_LONG_FLAGS, `SFDPD_LONG_PAT);

    always_comb begin
        hit = 1'b1;
        sel_word = 32'h0000_0000;
        case ({addr[ADDR_W-1:2], 2'b00})
            ADDR_W'(`SFDPD_VOL_BASE): sel_word = vol_word;
            ADDR_W'(`SFDPD_NVL_BASE): sel_word = nvl_word;
            ADDR_W'(`SFDPD_LONG_BASE): sel_word = long_w;
            default: hit = 1'b0;
        endcase
    end

    // Little-endian byte order within each word
    assign data = hit ? sel_word[8*addr[1:0] +: 8] : `SFDPD_UNMAPPED;

endmodule // sfdpd_rom

// file: hw/sfdpd_top.sv
`timescale 1ns/1ps
`include "sfdpd_map.svh"

module sfdpd_top
    import sfdpd_pkg::*;
#(
    parameter int ADDR_W = `SFDPD_ADDR_BITS,
    parameter int DUMMY_BITS = `SFDPD_DUMMY_BITS
) (
    // System
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    // Serial link, mode 0
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic si,
    output logic so,
    output logic so_oe
);

    // Limits the counters and the table lookup can serve
    if (ADDR_W < 10 || ADDR_W > 32) begin : g_addr_w_bad
        $error("sfdpd_top: ADDR_W out of range");
    end
    if (DUMMY_BITS < 1 || DUMMY_BITS > 32) begin : g_dummy_bad
        $error("sfdpd_top: DUMMY_BITS out of range");
    end

    localparam int BYTE_BITS = $bits(sfdpd_byte_t);

    sfdpd_state_t state_q;
    logic sclk_q;
    logic rise;
    logic fall;
    logic [7:0] cmd_q;
    logic [ADDR_W-1:0] addr_q;
    logic [5:0] cnt_q;
    logic [7:0] sh_q;
    logic first_q;
    logic [ADDR_W-1:0] rom_addr;
    sfdpd_byte_t rom_data;
    logic dummy_done;
    logic data_fall;
    logic byte_done;

    ////////////////////////////////////////////////////////////////////////////
    // Shared decodes

    // True on the last bit of a phase that is len bits long
    function automatic logic phase_end(input logic [5:0] cnt, input int len);
        phase_end = (cnt == 6'(len - 1));
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection

    always_ff @(posedge mclk) begin
        if (reset) begin
            sclk_q <= 1'b0;
        end else if (ce) begin
            sclk_q <= sclk;
        end
    end

    assign rise = !cs_n && sclk && !sclk_q;
    assign fall = !cs_n && !sclk && sclk_q;

    assign dummy_done = (state_q == SFDPD_DUMMY) && rise && phase_end(cnt_q, DUMMY_BITS);
    // The first fall after the header only ends the last dummy bit
    assign data_fall = (state_q == SFDPD_DATA) && fall && !first_q;
    assign byte_done = data_fall && phase_end(cnt_q, BYTE_BITS);

    ////////////////////////////////////////////////////////////////////////////
    // Phase sequencing

    always_ff @(posedge mclk) begin
        if (reset || (ce && cs_n)) begin
            state_q <= SFDPD_CMD;
        end else if (ce) begin
            case (state_q)
                SFDPD_CMD: begin
                    if (rise && phase_end(cnt_q, BYTE_BITS)) begin
                        state_q <= ({cmd_q[6:0], si} == `SFDPD_PARAM_RD_CMD) ?
                            SFDPD_ADDR : SFDPD_IGNORE;
                    end
                end
                SFDPD_ADDR: begin
                    if (rise && phase_end(cnt_q, ADDR_W)) begin
                        state_q <= SFDPD_DUMMY;
                    end
                end
                SFDPD_DUMMY: begin
                    if (dummy_done) begin
                        state_q <= SFDPD_DATA;
                    end
                end
                SFDPD_DATA: begin
                    state_q <= SFDPD_DATA;
                end
                SFDPD_IGNORE: begin
                    state_q <= SFDPD_IGNORE;
                end
                default: begin
                    state_q <= SFDPD_CMD;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bit counter within the current phase

    always_ff @(posedge mclk) begin
        if (reset || (ce && cs_n)) begin
            cnt_q <= 6'h00;
        end else if (ce) begin
            case (state_q)
                SFDPD_CMD: begin
                    if (rise) begin
                        cnt_q <= phase_end(cnt_q, BYTE_BITS) ? 6'h00 : cnt_q + 6'h01;
                    end
                end
                SFDPD_ADDR: begin
                    if (rise) begin
                        cnt_q <= phase_end(cnt_q, ADDR_W) ? 6'h00 : cnt_q + 6'h01;
                    end
                end
                SFDPD_DUMMY: begin
                    if (rise) begin
                        cnt_q <= phase_end(cnt_q, DUMMY_BITS) ? 6'h00 : cnt_q + 6'h01;
                    end
                end
                SFDPD_DATA: begin
                    if (data_fall) begin
                        cnt_q <= byte_done ? 6'h00 : cnt_q + 6'h01;
                    end
                end
                default: begin
                    cnt_q <= 6'h00;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command and address capture

    always_ff @(posedge mclk) begin
        if (reset || (ce && cs_n)) begin
            cmd_q <= 8'h00;
        end else if (ce && state_q == SFDPD_CMD && rise) begin
            cmd_q <= {cmd_q[6:0], si};
        end
    end

    always_ff @(posedge mclk) begin
        if (reset || (ce && cs_n)) begin
            addr_q <= '0;
        end else if (ce) begin
            if (state_q == SFDPD_ADDR && rise) begin
                addr_q <= {addr_q[ADDR_W-2:0], si};
            end else if (byte_done) begin
                addr_q <= addr_q + ADDR_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Table lookup

    assign rom_addr = (state_q == SFDPD_DATA) ? addr_q + ADDR_W'(1) : addr_q;

    sfdpd_rom #(
        .ADDR_W(ADDR_W)
    ) u_rom (
        .addr(rom_addr),
        .data(rom_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Output shifter, MSB first, loads on the last dummy rise, then shifts on falling clock

    always_ff @(posedge mclk) begin
        if (reset || (ce && cs_n)) begin
            sh_q <= 8'h00;
        end else if (ce) begin
            if (dummy_done) begin
                sh_q <= rom_data;
            end else if (data_fall) begin
                // Next byte loads as the last bit of this one ends
                sh_q <= byte_done ? rom_data : {sh_q[6:0], 1'b0};
            end
        end
    end

    // Marks that the first data bit already stands on the pin
    always_ff @(posedge mclk) begin
        if (reset || (ce && cs_n)) begin
            first_q <= 1'b0;
        end else if (ce) begin
            if (dummy_done) begin
                first_q <= 1'b1;
            end else if (state_q == SFDPD_DATA && fall) begin
                first_q <= 1'b0;
            end
        end
    end

    assign so = sh_q[7];
    assign so_oe = (state_q == SFDPD_DATA) && !cs_n;

endmodule // sfdpd_top

// file: pkg/sfdpd_map.svh
// Behaviour
// - Bytes 378h and 37Ch return 71h, the command that writes the latency register.
// - Bytes 379h and 37Dh return 65h, the command that reads the latency register back.
// - Byte 37Ah returns 04h, the address of the volatile third configuration register.
// - Byte 37Bh returns 94h: variable latency, two-bit field, field LSB at bit 4.
// - Byte 37Eh returns 04h, the address of the non-volatile third configuration register.
// - Byte 37Fh returns D0h: variable latency, four-bit field, field LSB at bit 0.
// - A locator word holds support in bit 31, width code in 30:29, addressed access in 28, LSB in 26:24.
// - Bit 27 of every locator word reads zero, so the register is not picked by the last address byte.
// - Bytes 380h to 383h all return 00h, as 22 to 30 dummy cycles are not offered.
// - The long-latency word has flags at bits 31, 25, 19, 13, 7, five-bit patterns after each, 1:0 zero.
`ifndef SFDPD_MAP_SVH
`define SFDPD_MAP_SVH

// Table placement
`define SFDPD_VOL_BASE 24'h000378
`define SFDPD_NVL_BASE 24'h00037C
`define SFDPD_LONG_BASE 24'h000380

// Locator word contents
`define SFDPD_WR_CMD 8'h71
`define SFDPD_RD_CMD 8'h65
`define SFDPD_CR3_ADDR 8'h04
`define SFDPD_VOL_WIDTH 2'b00
`define SFDPD_NVL_WIDTH 2'b10
`define SFDPD_VOL_LSB 3'h4
`define SFDPD_NVL_LSB 3'h0
`define SFDPD_SUPPORTED 1'b1
`define SFDPD_ADDRESSED 1'b1
`define SFDPD_LAST_BYTE 1'b0

// Long latency word: five flags, five patterns, all absent
`define SFDPD_LONG_FLAGS 5'h00
`define SFDPD_LONG_PAT 5'h00
`define SFDPD_RSVD 2'h0

// Answer outside this segment
`define SFDPD_UNMAPPED 8'hFF

// Serial protocol
`define SFDPD_PARAM_RD_CMD 8'h5A
`define SFDPD_ADDR_BITS 24
`define SFDPD_DUMMY_BITS 8

`endif

// file: pkg/sfdpd_pkg.sv
package sfdpd_pkg;

    typedef enum logic [4:0] {
        SFDPD_CMD = 5'h01,
        SFDPD_ADDR = 5'h02,
        SFDPD_DUMMY = 5'h04,
        SFDPD_DATA = 5'h08,
        SFDPD_IGNORE = 5'h10
    } sfdpd_state_t;

    typedef logic [7:0] sfdpd_byte_t;

endpackage

// file: verification/sfdpd_host_model.sv
`timescale 1ns/1ps
module sfdpd_host_model (
    // Clock
    input wire logic mclk,
    // Serial link
    output logic cs_n,
    output logic sclk,
    output logic si,
    input wire logic so,
    input wire logic so_oe
);
    logic [7:0] rx [0:15];
    logic oe_seen;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
        oe_seen = 1'b0;
    end
    // Each sclk level held half mclk cycles, so sampled at the rise
    task automatic clk_bit(input logic b, input int half, output logic r);
        si = b;
        repeat (half) @(posedge mclk);
        #1 sclk = 1'b1;
        r = so;
        repeat (half) @(posedge mclk);
        #1 sclk = 1'b0;
    endtask
    task automatic frame(input logic [7:0] cmd, input logic [23:0] a, input int n, input int half);
        logic [39:0] hdr;
        logic r;
        hdr = {cmd, a, 8'hA5};
        oe_seen = 1'b0;
        @(posedge mclk) #1 cs_n = 1'b0;
        for (int i = 39; i >= 0; i--) clk_bit(hdr[i], half, r);
        for (int k = 0; k < n; k++)
            for (int j = 7; j >= 0; j--) begin
                clk_bit(~si, half, r);
                rx[k][j] = r;
                oe_seen |= so_oe;
            end
        @(posedge mclk) #1 cs_n = 1'b1;
        @(posedge mclk);
    endtask
endmodule // sfdpd_host_model

// file: verification/sfdpd_top_bench.sv
`timescale 1ns/1ps
module sfdpd_top_bench;
    logic mclk;
    logic reset;
    logic ce;
    logic cs_n;
    logic sclk;
    logic si;
    logic so;
    logic so_oe;
    int fails;
    int compares;
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    sfdpd_top dut (.mclk(mclk), .reset(reset), .ce(ce), .cs_n(cs_n), .sclk(sclk), .si(si),
        .so(so), .so_oe(so_oe));
    sfdpd_host_model host (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so),
        .so_oe(so_oe));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] exp_byte(input logic [23:0] a);
        case (a)
            24'h000378, 24'h00037C: return 8'h71;
            24'h000379, 24'h00037D: return 8'h65;
            24'h00037A, 24'h00037E: return 8'h04;
            24'h00037B: return 8'h94;
            24'h00037F: return 8'hD0;
            24'h000380, 24'h000381, 24'h000382, 24'h000383: return 8'h00;
            default: return 8'hFF;
        endcase
    endfunction
    task automatic read_chk(input logic [23:0] a, input int n, input int half);
        host.frame(8'h5A, a, n, half);
        for (int k = 0; k < n; k++)
            check({24'h0, host.rx[k]}, {24'h0, exp_byte(a + 24'(k))});
    endtask
    task automatic give_verdict;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge mclk);
        fails++;
        give_verdict();
    end
    initial begin
        fails = 0;
        compares = 0;
        ce = 1'b1;
        reset = 1'b1;
        void'($urandom(88362));
        repeat (20) @(posedge mclk);
        #1 reset = 1'b0;
        check({30'h0, so, so_oe}, 32'h0);
        read_chk(24'h000378, 12, 2);
        check({host.rx[3], host.rx[2], host.rx[1], host.rx[0]}, 32'h9404_6571);
        check({host.rx[7], host.rx[6], host.rx[5], host.rx[4]}, 32'hD004_6571);
        check({host.rx[11], host.rx[10], host.rx[9], host.rx[8]}, 32'h0);
        $display("test sweep done");
        for (int i = 0; i < 16; i++)
            read_chk(24'h000374 + 24'($urandom_range(19)), $urandom_range(6, 1),
                $urandom_range(4, 2));
        $display("test random done");
        host.frame(8'h03, 24'h000378, 2, 2);
        check({31'h0, host.oe_seen}, 32'h0);
        $display("test refused done");
        give_verdict();
    end
endmodule // sfdpd_top_bench

// file: verification/sfdpd_top_props.sv
`timescale 1ns/1ps
module sfdpd_top_props
    import sfdpd_pkg::*;
#(
    parameter int ADDR_W = 24,
    parameter int DUMMY_BITS = 8
) (
    // Watched ports
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe
);
    localparam int HDR = 8 + ADDR_W + DUMMY_BITS;
    logic sclk_q;
    logic [6:0] rises_q;
    always_ff @(posedge mclk) begin
        if (reset) sclk_q <= 1'b0;
        else if (ce) sclk_q <= sclk;
    end
    // Rising serial edges taken in this frame
    always_ff @(posedge mclk) begin
        if (reset || (ce && cs_n)) rises_q <= 7'h00;
        else if (ce && sclk && !sclk_q && rises_q != 7'h7F) rises_q <= rises_q + 7'h01;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    AST_OE_DROP: assert property (ce && cs_n |=> !so_oe)
        else $error("so_oe held after deselect");
    AST_OE_SEL: assert property (so_oe |-> !$past(cs_n))
        else $error("so_oe without select");
    AST_OE_HOLD: assert property (so_oe && ce && !cs_n ##1 !cs_n |-> so_oe)
        else $error("so_oe dropped in frame");
    AST_OE_START: assert property ($rose(so_oe) |-> rises_q == HDR)
        else $error("so_oe rose at wrong count");
    AST_OE_EDGE: assert property ($rose(so_oe) |-> $past(sclk) && !$past(sclk, 2))
        else $error("so_oe not after rising sclk");
    AST_OE_EARLY: assert property (so_oe |-> rises_q >= HDR)
        else $error("so_oe before header done");
    AST_SO_HOLD: assert property (so_oe && ce && !cs_n && !(sclk_q && !sclk)
        && !$past(sclk_q && !sclk) |=> $stable(so))
        else $error("so moved without falling sclk");
    AST_SO_FIRST: assert property ($rose(so_oe) |=> $stable(so) [*3])
        else $error("first bit shifted early");
endmodule // sfdpd_top_props

bind sfdpd_top sfdpd_top_props #(.ADDR_W(ADDR_W), .DUMMY_BITS(DUMMY_BITS)) u_props (
    .mclk(mclk), .reset(reset), .ce(ce), .cs_n(cs_n), .sclk(sclk), .si(si),
    .so(so), .so_oe(so_oe));
